// ### logic/act_pkg.sv
// constants, tables and register map of the conversion timing and filter control block
package act_pkg;
	// clock
	localparam int CLK_MHZ = 20;
	localparam int CLK_PERIOD_NS = 50;
	// modulator dividers
	localparam int DIV_NORM = 16;
	localparam int DIV_TURBO = 8;
	localparam logic [3:0] HALF_NORM = 4'(DIV_NORM / 2 - 1);
	localparam logic [3:0] HALF_TURBO = 4'(DIV_TURBO / 2 - 1);
	// first-conversion lead in system clocks
	localparam int LEAD_NORM = 210;
	localparam int LEAD_TURBO = 114;
	// oscillator wake-up bound, longest time rounds down
	localparam int WAKE_NORM_US = 50;
	localparam int WAKE_TURBO_US = 25;
	localparam int WAKE_NORM_CYC = (WAKE_NORM_US * CLK_MHZ * 1000) / 1000;
	localparam int WAKE_TURBO_CYC = (WAKE_TURBO_US * CLK_MHZ * 1000) / 1000;
	// conversion tables, index = row*7 + rate, row 0 normal (and mode code 3), 1 duty, 2 turbo
	localparam int RATES = 7;
	localparam logic [19:0] CONT_DEF [0:20] = '{204768, 91120, 46128, 23664, 12464, 6896, 4144,
		823120, 364560, 184592, 94736, 49936, 27664, 16656,
		102384, 45560, 23064, 11832, 6232, 3448, 2072};
	// duty-cycle single-shot rows repeat the normal rows
	localparam logic [19:0] SINGLE_DEF [0:20] = '{204850, 91218, 46226, 23762, 12562, 6994, 4242,
		204850, 91218, 46226, 23762, 12562, 6994, 4242,
		102434, 45618, 23122, 11890, 6290, 3506, 2130};
	// register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_RESULT = 8'h0c;
	localparam logic [7:0] ADDR_INT_STAT = 8'h10;
	localparam logic [7:0] ADDR_INT_MASK = 8'h14;
	// control fields
	localparam int CTL_W = 13;
	localparam int CTL_MODE = 0;
	localparam int CTL_RATE = 2;
	localparam int CTL_REJ = 5;
	localparam int CTL_SINGLE = 7;
	localparam int CTL_BYP = 8;
	localparam int CTL_GAIN = 9;
	localparam int CTL_INTOSC = 12;
	localparam logic [CTL_W-1:0] CTRL_RST = 13'h1000;
	localparam logic [1:0] MODE_DUTY = 2'h1;
	localparam logic [1:0] MODE_TURBO = 2'h2;
	localparam logic [2:0] RATE_LAST = 3'h6;
	localparam logic [2:0] RATE_REJ = 3'h0;
	localparam logic [2:0] GAIN_BYP_MAX = 3'h2;
	// command bits
	localparam int CMD_LAUNCH = 0;
	localparam int CMD_STOP = 1;
	// interrupt bits
	localparam int INT_W = 2;
	localparam int INT_DONE = 0;
	localparam int INT_OSC_LATE = 1;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {S_IDLE, S_WAKE, S_LEAD, S_CONV} act_state_e;
endpackage

// ### logic/act_conv_ctrl.sv
// conversion timing, modulator divider, filter set-up and axi4-lite registers
`timescale 1ns/100ps
module act_conv_ctrl import act_pkg::*; #(
	parameter logic [19:0] CONT_CYC [0:20] = CONT_DEF,
	parameter logic [19:0] SINGLE_CYC [0:20] = SINGLE_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial command decoder and oscillator pins
	input wire logic launch_active,
	input wire logic osc_ready,
	output logic osc_pwr_en,
	// modulator and filter
	output logic mod_clk,
	output logic [1:0] filt_mode_sel,
	output logic [2:0] filt_rate_sel,
	output logic [1:0] filt_notch_sel,
	input wire logic [15:0] filt_result,
	// amplifier
	output logic amp_bypass_bit,
	output logic gain_amplifier_en,
	output logic [2:0] gain_sel,
	// result and interrupt
	output logic result_ready_n,
	output logic [15:0] conv_result,
	output logic irq
);
	typedef struct packed {
		logic launch_s1;
		logic launch_s2;
		logic launch_q;
		logic osc_s1;
		logic osc_s2;
		logic [CTL_W-1:0] ctrl;
		act_state_e state;
		logic [19:0] cnt;
		logic [19:0] tgt;
		logic [19:0] age;
		logic [10:0] wake;
		logic [3:0] div;
		logic mod_clk;
		logic ready;
		logic [15:0] result;
		logic [INT_W-1:0] int_stat;
		logic [INT_W-1:0] int_mask;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} act_st_s;

	act_st_s st_reg;
	act_st_s st_next;
	logic [1:0] mode;
	logic [2:0] rate;
	logic turbo;
	logic [4:0] idx;
	logic launch_evt;
	logic stop_evt;
	logic conv_done;
	logic wr_go;
	logic rd_go;
	logic [31:0] wmask;
	logic [19:0] lead_cyc;
	logic [10:0] wake_cyc;

	// decoded settings; unknown rate codes fall back to the last rate, 6
	assign mode = st_reg.ctrl[CTL_MODE +: 2];
	assign rate = (st_reg.ctrl[CTL_RATE +: 3] > RATE_LAST) ? RATE_LAST : st_reg.ctrl[CTL_RATE +: 3];
	assign turbo = (mode == MODE_TURBO);
	assign idx = 5'((turbo ? 2 : (mode == MODE_DUTY) ? 1 : 0) * RATES) + 5'(rate);
	assign lead_cyc = turbo ? 20'(LEAD_TURBO) : 20'(LEAD_NORM);
	assign wake_cyc = turbo ? 11'(WAKE_TURBO_CYC) : 11'(WAKE_NORM_CYC);
	assign wr_go = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
	assign rd_go = s_axi_arvalid && !st_reg.rvalid;
	assign wmask = {{8{st_reg.w_strb[3]}}, {8{st_reg.w_strb[2]}}, {8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
	// launch ends at the last serial clock falling edge or on a software command
	assign launch_evt = (st_reg.launch_q && !st_reg.launch_s2)
		|| (wr_go && st_reg.aw_addr == ADDR_CMD && st_reg.w_strb[0] && st_reg.w_data[CMD_LAUNCH]);
	assign stop_evt = wr_go && st_reg.aw_addr == ADDR_CMD && st_reg.w_strb[0] && st_reg.w_data[CMD_STOP];
	assign conv_done = (st_reg.state == S_CONV) && (st_reg.cnt == 20'h00000);

	// next-state logic for the whole block
	always_comb begin
		st_next = st_reg;
		// pin synchronisers
		st_next.launch_s1 = launch_active;
		st_next.launch_s2 = st_reg.launch_s1;
		st_next.launch_q = st_reg.launch_s2;
		st_next.osc_s1 = osc_ready;
		st_next.osc_s2 = st_reg.osc_s1;
		// modulator divider, restarts cleanly on the half-period count
		if (st_reg.div >= (turbo ? HALF_TURBO : HALF_NORM)) begin
			st_next.div = 4'h0;
			st_next.mod_clk = !st_reg.mod_clk;
		end else begin
			st_next.div = st_reg.div + 4'h1;
		end
		st_next.age = st_reg.age + 20'h00001;
		// conversion sequencer, all counts in system clocks
		if (stop_evt) begin
			st_next.state = S_IDLE;
		end else if (launch_evt) begin
			st_next.wake = 11'h000;
			if (st_reg.ctrl[CTL_INTOSC] && !st_reg.osc_s2) begin
				st_next.state = S_WAKE;
			end else if (st_reg.ctrl[CTL_SINGLE]) begin
				st_next.state = S_CONV;
				st_next.cnt = SINGLE_CYC[idx] - 20'h00001;
				st_next.tgt = SINGLE_CYC[idx];
				st_next.age = 20'h00000;
			end else begin
				st_next.state = S_LEAD;
				st_next.cnt = lead_cyc - 20'h00001;
				st_next.tgt = lead_cyc;
				st_next.age = 20'h00000;
			end
		end else begin
			unique case (st_reg.state)
				S_IDLE: begin
				end
				S_WAKE: begin
					st_next.wake = st_reg.wake + 11'h001;
					if (st_reg.osc_s2 || st_reg.wake >= wake_cyc) begin
						st_next.age = 20'h00000;
						if (st_reg.ctrl[CTL_SINGLE]) begin
							st_next.state = S_CONV;
							st_next.cnt = SINGLE_CYC[idx] - 20'h00001;
							st_next.tgt = SINGLE_CYC[idx];
						end else begin
							st_next.state = S_LEAD;
							st_next.cnt = lead_cyc - 20'h00001;
							st_next.tgt = lead_cyc;
						end
					end
				end
				S_LEAD: begin
					if (st_reg.cnt == 20'h00000) begin
						st_next.state = S_CONV;
						st_next.cnt = CONT_CYC[idx] - 20'h00001;
						st_next.tgt = CONT_CYC[idx];
						st_next.age = 20'h00000;
					end else begin
						st_next.cnt = st_reg.cnt - 20'h00001;
					end
				end
				S_CONV: begin
					if (conv_done) begin
						// continuous mode reloads for the next period
						st_next.cnt = CONT_CYC[idx] - 20'h00001;
						st_next.tgt = CONT_CYC[idx];
						st_next.age = 20'h00000;
						if (st_reg.ctrl[CTL_SINGLE]) begin
							st_next.state = S_IDLE;
						end
					end else begin
						st_next.cnt = st_reg.cnt - 20'h00001;
					end
				end
			endcase
		end
		// axi write channel capture in either order
		if (s_axi_awvalid && !st_reg.aw_have) begin
			st_next.aw_have = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_have) begin
			st_next.w_have = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (wr_go) begin
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = RESP_OKAY;
			unique case (st_reg.aw_addr)
				ADDR_CTRL: st_next.ctrl = CTL_W'((32'(st_reg.ctrl) & ~wmask) | (st_reg.w_data & wmask));
				ADDR_CMD, ADDR_STATUS, ADDR_RESULT: begin
				end
				ADDR_INT_STAT: st_next.int_stat = st_reg.int_stat & ~(st_reg.w_data[INT_W-1:0] & wmask[INT_W-1:0]);
				ADDR_INT_MASK: st_next.int_mask = (st_reg.int_mask & ~wmask[INT_W-1:0]) | (st_reg.w_data[INT_W-1:0] & wmask[INT_W-1:0]);
				default: st_next.bresp = RESP_SLVERR;
			endcase
		end
		// axi read
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = RESP_OKAY;
			st_next.rdata = 32'h00000000;
			unique case (s_axi_araddr)
				ADDR_CTRL: st_next.rdata = 32'(st_reg.ctrl);
				ADDR_CMD: begin
				end
				ADDR_STATUS: st_next.rdata = {28'h0000000, st_reg.state == S_WAKE, st_reg.osc_s2, st_reg.ready, st_reg.state != S_IDLE};
				ADDR_RESULT: begin
					st_next.rdata = {16'h0000, st_reg.result};
					st_next.ready = 1'b0;
				end
				ADDR_INT_STAT: st_next.rdata = 32'(st_reg.int_stat);
				ADDR_INT_MASK: st_next.rdata = 32'(st_reg.int_mask);
				default: st_next.rresp = RESP_SLVERR;
			endcase
		end
		// a new result wins over a read or clear in the same cycle
		if (conv_done) begin
			st_next.result = filt_result;
			st_next.ready = 1'b1;
			st_next.int_stat[INT_DONE] = 1'b1;
		end
		if (st_reg.state == S_WAKE && (st_reg.osc_s2 || st_reg.wake >= wake_cyc) && !st_reg.osc_s2 && !launch_evt) begin
			st_next.int_stat[INT_OSC_LATE] = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
			st_reg.ctrl <= CTRL_RST;
			st_reg.state <= S_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// bus handshakes
	assign s_axi_awready = !st_reg.aw_have;
	assign s_axi_wready = !st_reg.w_have;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;

	// analog-side settings; counting in clk cycles keeps every time proportional to the clock
	assign mod_clk = st_reg.mod_clk;
	assign filt_mode_sel = mode;
	assign filt_rate_sel = rate;
	assign filt_notch_sel = (rate == RATE_REJ && !turbo) ? st_reg.ctrl[CTL_REJ +: 2] : 2'h0;
	assign amp_bypass_bit = st_reg.ctrl[CTL_BYP] && (st_reg.ctrl[CTL_GAIN +: 3] <= GAIN_BYP_MAX);
	assign gain_amplifier_en = !amp_bypass_bit;
	assign gain_sel = st_reg.ctrl[CTL_GAIN +: 3];
	// oscillator powers up from the first serial clock rise of the launch command
	assign osc_pwr_en = st_reg.ctrl[CTL_INTOSC] && (st_reg.launch_s2 || st_reg.launch_q || st_reg.state != S_IDLE);
	assign result_ready_n = !st_reg.ready;
	assign conv_result = st_reg.result;
	assign irq = |(st_reg.int_stat & st_reg.int_mask);

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_mod_half;
		$rose(st_reg.mod_clk) && !turbo |-> (st_reg.mod_clk [*8] ##1 !st_reg.mod_clk) or (##[1:8] turbo);
	endproperty
	a_mod_half: assert property (p_mod_half) else $error("modulator half period wrong");
	property p_lead_norm;
		$rose(st_reg.state == S_LEAD) && !turbo && !launch_evt && !stop_evt |-> ##210 (st_reg.state == S_CONV) || $past(launch_evt || stop_evt);
	endproperty
	a_lead_norm: assert property (p_lead_norm) else $error("first conversion lead wrong");
	property p_conv_len;
		conv_done |-> st_reg.age == st_reg.tgt - 20'h00001;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
	property p_wake_bound;
		st_reg.state == S_WAKE |-> st_reg.wake <= wake_cyc;
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("oscillator wait too long");
	property p_osc_pwr;
		$rose(st_reg.launch_s2) && st_reg.ctrl[CTL_INTOSC] |-> osc_pwr_en;
	endproperty
	a_osc_pwr: assert property (p_osc_pwr) else $error("oscillator not powered at launch");
	property p_hold_off;
		st_reg.state == S_WAKE && !st_reg.osc_s2 && st_reg.wake < wake_cyc && !stop_evt && !launch_evt |=> st_reg.state == S_WAKE;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("conversion began before oscillator ready");
	property p_notch;
		filt_notch_sel != 2'h0 |-> rate == RATE_REJ && !turbo;
	endproperty
	a_notch: assert property (p_notch) else $error("line rejection at wrong rate");
	property p_bypass;
		amp_bypass_bit |-> gain_sel <= GAIN_BYP_MAX && !gain_amplifier_en;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass at illegal gain");
	property p_ready_low;
		conv_done |=> !result_ready_n && conv_result == $past(filt_result);
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("result not flagged");
	property p_irq;
		conv_done && st_reg.int_mask[INT_DONE] |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("done interrupt missing");
	// turbo lead, single-shot end, oscillator power across launch end, sticky late flag
	property p_lead_turbo;
		$rose(st_reg.state == S_LEAD) && turbo && !launch_evt && !stop_evt |-> ##114 (st_reg.state == S_CONV) || $past(launch_evt || stop_evt);
	endproperty
	a_lead_turbo: assert property (p_lead_turbo) else $error("turbo first conversion lead wrong");
	property p_single_idle;
		conv_done && st_reg.ctrl[CTL_SINGLE] && !launch_evt && !stop_evt |=> st_reg.state == S_IDLE;
	endproperty
	a_single_idle: assert property (p_single_idle) else $error("single-shot did not stop");
	property p_osc_gap;
		st_reg.ctrl[CTL_INTOSC] && $fell(st_reg.launch_s2) |-> osc_pwr_en;
	endproperty
	a_osc_gap: assert property (p_osc_gap) else $error("oscillator power dropped at launch end");
	property p_late_sticky;
		st_reg.int_stat[INT_OSC_LATE] && !(wr_go && st_reg.aw_addr == ADDR_INT_STAT && st_reg.w_strb[0] && st_reg.w_data[INT_OSC_LATE]) |=> st_reg.int_stat[INT_OSC_LATE];
	endproperty
	a_late_sticky: assert property (p_late_sticky) else $error("oscillator late flag lost");
	c_single: cover property (conv_done && st_reg.ctrl[CTL_SINGLE]);
	c_cont_two: cover property (conv_done && !st_reg.ctrl[CTL_SINGLE] ##[1:1000] conv_done);
	c_wake: cover property (st_reg.state == S_WAKE ##1 st_reg.state == S_CONV);
	c_slverr: cover property (st_reg.bvalid && st_reg.bresp == RESP_SLVERR);
endmodule // act_conv_ctrl

// ### tb/act_host_model.sv
// far-side model: host launch command, internal oscillator and filter output
`timescale 1ns/100ps
module act_host_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// bench requests
	input wire logic send,
	input wire logic [15:0] sclk_half,
	input wire logic [15:0] osc_delay,
	input wire logic [15:0] sample,
	// pins of the block
	input wire logic osc_pwr_en,
	output logic launch_active,
	output logic osc_ready,
	output logic [15:0] filt_result
);
	logic [15:0] ocnt;
	// launch command, eight serial clocks from first rise to last fall
	initial launch_active = 1'b0;
	always @(posedge clk) begin
		if (send && !launch_active) begin
			launch_active <= 1'b1;
			repeat (16 * sclk_half) @(posedge clk);
			launch_active <= 1'b0;
		end
	end
	// oscillator is up osc_delay cycles after power, drops with power
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ocnt <= 16'h0;
			osc_ready <= 1'b0;
		end else if (!osc_pwr_en) begin
			ocnt <= 16'h0;
			osc_ready <= 1'b0;
		end else if (ocnt >= osc_delay)
			osc_ready <= 1'b1;
		else
			ocnt <= ocnt + 16'h1;
	end
	// filter output held steady by the bench for each conversion
	assign filt_result = sample;
endmodule  // act_host_model

// ### tb/tb_top.sv
// self-checking bench for the conversion timing and filter control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top import act_pkg::*; ;
	localparam int TOL = 4;
	logic clk, rst_b, send;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, fmode, notch;
	logic launch, osc_rdy, osc_pwr, mod_clk, byp, amp_en, rdy_n, rdy_q, irq;
	logic [2:0] frate, gsel, g;
	logic [15:0] fres, cres, sample, sclk_half, osc_delay;
	logic [33:0] e34;
	logic [33:0] rd_q[$];
	int t_q[$];
	int d, e, miscompares, tests_run, cyc, mark;
	int cont[3] = '{4144, 16656, 3448};
	int sing[3] = '{4242, 4242, 3506};
	logic [2:0] rsel[3] = '{3'h6, 3'h6, 3'h5};
	act_conv_ctrl act_conv_ctrl_i (.clk(clk), .rst_b(rst_b),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .launch_active(launch), .osc_ready(osc_rdy), .osc_pwr_en(osc_pwr),
		.mod_clk(mod_clk), .filt_mode_sel(fmode), .filt_rate_sel(frate), .filt_notch_sel(notch),
		.filt_result(fres), .amp_bypass_bit(byp), .gain_amplifier_en(amp_en), .gain_sel(gsel),
		.result_ready_n(rdy_n), .conv_result(cres), .irq(irq));
	act_host_model act_host_model_i (.clk(clk), .rst_b(rst_b), .send(send), .sclk_half(sclk_half),
		.osc_delay(osc_delay), .sample(sample), .osc_pwr_en(osc_pwr), .launch_active(launch),
		.osc_ready(osc_rdy), .filt_result(fres));
	// 20 MHz system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// verdict and end of run
	task automatic final_report;
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// control word: internal osc, single-shot, rate, mode
	function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] r, input logic s, input logic o);
		return {19'h0, o, 4'h0, s, 2'h0, r, m};
	endfunction
	// bus write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
		logic ta, tw;
		@(posedge clk);
		ta = 1'b0;
		tw = 1'b0;
		awaddr <= a;
		wdata <= dat;
		{awvalid, wvalid, bready} <= 3'h7;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (awvalid && awready)
				ta = 1'b1;
			if (wvalid && wready)
				tw = 1'b1;
			awvalid <= !ta;
			wvalid <= !tw;
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask
	// bus read, expected answer noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [33:0] ex);
		@(posedge clk);
		rd_q.push_back(ex);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask
	// one launch command; cycles count from its last serial clock
	task automatic launch_cmd(input int ex);
		t_q.push_back(ex);
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
		while (launch) @(posedge clk);
		mark = cyc;
	endtask
	// wait for a result, fetch it and see result-ready return high
	task automatic take(input int n);
		while (t_q.size() > n) @(posedge clk);
		`CHK("conv_result", sample, cres)
		rd(ADDR_RESULT, {RESP_OKAY, 16'h0, sample});
		@(posedge clk);
		#1;
		`CHK("ready_n", 1'b1, rdy_n)
	endtask
	// full modulator clock period in system clocks
	task automatic modper(input int p);
		int n;
		n = 0;
		repeat (2) begin
			while (mod_clk) @(posedge clk);
			while (!mod_clk) @(posedge clk);
		end
		do begin
			n++;
			@(posedge clk);
		end while (mod_clk);
		while (!mod_clk) begin
			n++;
			@(posedge clk);
		end
		`CHK("mod_period", p, n)
	endtask
	// monitor: read answers and result-ready falls take the oldest note
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rdy_q <= rdy_n;
		if (rvalid && rready) begin
			e34 = rd_q.pop_front();
			`CHK("rdata", e34, {rresp, rdata})
		end
		if (rst_b && !rdy_n && rdy_q) begin
			e = t_q.pop_front();
			d = cyc - mark;
			// synchroniser and state edges get a few cycles of slack
			if (d >= e - TOL && d <= e + TOL)
				d = e;
			`CHK("conv_cycles", e, d)
			mark <= cyc;
		end
		if (cyc > 90000) begin
			miscompares++;
			final_report();
		end
	end
	// main sequence
	initial begin
		rst_b = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, send} = '0;
		{awaddr, araddr, wdata, sample} = '0;
		wstrb = 4'hf;
		sclk_half = 16'h4;
		osc_delay = 16'd20;
		void'($urandom(32'h98fe));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rd(ADDR_CTRL, {RESP_OKAY, 32'h1000});
		rd(8'h3c, {RESP_SLVERR, 32'h0});
		wr(8'h3c, 32'h1, RESP_SLVERR);
		`CHK("ready_n", 1'b1, rdy_n)
		// filter and amplifier selects follow the control word
		for (int i = 0; i < 9; i++) begin
			g = 3'($urandom);
			wr(ADDR_CTRL, {19'h0, 1'b0, g, 1'b1, 1'b0, 2'(i), 3'(i / 6), 2'((i / 2) % 3)}, RESP_OKAY);
			#1;
			`CHK("mode", 2'((i / 2) % 3), fmode)
			`CHK("rate", 3'(i / 6), frate)
			`CHK("notch", (i < 4) ? 2'(i) : 2'h0, notch)
			`CHK("bypass", g <= 3'h2, byp)
			`CHK("amp_en", g > 3'h2, amp_en)
			`CHK("gain", g, gsel)
		end
		// modulator divider per mode, code 3 runs as normal
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CTRL, 32'(m), RESP_OKAY);
			modper(m == 2 ? 8 : 16);
		end
		// single-shot at rate 6 for normal and duty and rate 5 for turbo, duty reuses the normal count
		for (int m = 0; m < 3; m++) begin
			sample <= 16'($urandom);
			wr(ADDR_CTRL, cfg(2'(m), rsel[m], 1'b1, 1'b0), RESP_OKAY);
			launch_cmd(sing[m] + 4);
			take(0);
		end
		// continuous per mode: lead, one period per result, then stop
		for (int m = 0; m < 3; m++) begin
			wr(ADDR_CTRL, cfg(2'(m), rsel[m], 1'b0, 1'b0), RESP_OKAY);
			launch_cmd((m == 2 ? 114 : 210) + cont[m] + 4);
			t_q.push_back(cont[m]);
			take(1);
			take(0);
			wr(ADDR_CMD, 32'h2, RESP_OKAY);
		end
		// internal oscillator woken during the command, then one that stays late
		wr(ADDR_INT_STAT, 32'h3, RESP_OKAY);
		wr(ADDR_CTRL, cfg(2'h0, 3'h6, 1'b1, 1'b1), RESP_OKAY);
		launch_cmd(sing[0] + 4);
		take(0);
		osc_delay <= 16'd5000;
		launch_cmd(sing[0] + 1000 + 4);
		take(0);
		rd(ADDR_INT_STAT, {RESP_OKAY, 32'h3});
		`CHK("irq", 1'b0, irq)
		wr(ADDR_INT_MASK, 32'h2, RESP_OKAY);
		#1;
		`CHK("irq", 1'b1, irq)
		wr(ADDR_INT_STAT, 32'h2, RESP_OKAY);
		#1;
		`CHK("irq", 1'b0, irq)
		rd(ADDR_INT_STAT, {RESP_OKAY, 32'h1});
		rd(ADDR_INT_MASK, {RESP_OKAY, 32'h2});
		final_report();
	end
endmodule  // tb_top
